// ===== inc/msc_map.svh
`ifndef MSC_MAP_SVH
`define MSC_MAP_SVH
// Management map addresses
`define MSC_ADDR_STATUS 8'h00
`define MSC_ADDR_FLAGS 8'h01
`define MSC_ADDR_CTRL 8'h02
// Field positions in the exported map word
`define MSC_MAP_PENDING 0
`define MSC_MAP_LOWPWR 1
`define MSC_MAP_FAULT 2
`define MSC_MAP_FLAGS 3
`define MSC_MAP_CTRL 5
// Flag and control bit positions
`define MSC_FL_RSTDONE 0
`define MSC_FL_FAULT 1
`define MSC_CT_FAULT_EN 0
`define MSC_CT_TX_OFF 1
`define MSC_CTRL_RST 2'h1
// Frame layout in link clock bits, device count
`define MSC_ADDR_LAST 5'h08
`define MSC_DATA_LAST 5'h10
// Host bit index: 0 framing, 1 direction, 17 last data bit
`define MSC_HB_FIRST_DATA 5'h0A
`define MSC_HB_LAST 5'h11
// Timing counts
`define MSC_RST_MIN_CYC 16'h0014
`define MSC_INIT_CYC 16'h0010
`define MSC_HOST_RST_CYC 16'h0040
`define MSC_CLK_KHZ 200000
`define MSC_SCL_KHZ 400
`define MSC_SCL_HALF_CYC (`MSC_CLK_KHZ / (2 * `MSC_SCL_KHZ))
`endif

// ===== inc/msc_pkg.sv
package msc_pkg;
  typedef enum logic [1:0] {CORE_INIT, CORE_HOLD, CORE_RUN} msc_core_st_t;
  typedef enum logic [2:0] {H_IDLE, H_LOW, H_HIGH, H_RST} msc_host_st_t;

  // Device state on the link clock
  typedef struct packed {
    logic [4:0] cnt;
    logic rw;
    logic [7:0] addr;
    logic [7:0] sh;
    logic sda_oe_n;
    logic wr_tog;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [6:0] map_s1;
    logic [6:0] map_s2;
  } msc_link_t;

  // Device state on the system clock
  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic lp_s1;
    logic lp_s2;
    logic tog_s1;
    logic tog_s2;
    logic tog_s3;
    msc_core_st_t st;
    logic [15:0] low_cnt;
    logic [15:0] init_cnt;
    logic pending;
    logic fault_q;
    logic [1:0] flags;
    logic [1:0] ctrl;
    logic int_oe_n;
    logic pres_oe_n;
    logic [1:0] tx_ret;
    logic [1:0] tx_sym;
    logic tx_en;
    logic [1:0] rx_ret;
    logic [3:0] rx_lane;
    logic [6:0] map;
  } msc_core_t;

  // Host state
  typedef struct packed {
    msc_host_st_t st;
    logic [7:0] div;
    logic [4:0] hb;
    logic busy;
    logic rd_op;
    logic [16:0] frm;
    logic [7:0] rd;
    logic scl;
    logic sel_n;
    logic sda_oe_n;
    logic rst_n;
    logic [15:0] rst_cnt;
    logic lp;
    logic ready;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic int_s1;
    logic int_s2;
    logic pres_s1;
    logic pres_s2;
    logic sda_s1;
    logic sda_s2;
    logic stat_valid;
    logic irq;
    logic present;
    logic [3:0] tx_lane;
    logic [1:0] rx;
  } msc_host_t;

  // Binary to Gray and back; the map is its own inverse
  function automatic logic [1:0] msc_gray2(input logic [1:0] v);
    msc_gray2 = {v[1], v[1] ^ v[0]};
  endfunction
endpackage

// ===== inc/msc_if.sv
`timescale 1ns/1ps
interface msc_if;
  logic scl;
  logic sda_host_o;
  logic sda_host_oe_n;
  logic sda_dev_o;
  logic sda_dev_oe_n;
  logic sda;
  logic module_select_n;
  logic module_reset_n;
  logic low_power_select;
  logic present_o;
  logic present_oe_n;
  logic module_present_n;
  logic int_o;
  logic int_oe_n;
  logic interrupt_n;
  logic [3:0] tx_lane;
  logic [3:0] rx_lane;

  // Wired lines with pull-ups: any enabled low driver wins
  assign sda = !((!sda_host_oe_n && !sda_host_o) || (!sda_dev_oe_n && !sda_dev_o));
  assign interrupt_n = !(!int_oe_n && !int_o); // RQ11
  assign module_present_n = !(!present_oe_n && !present_o);

  modport dev (input scl, sda, module_select_n, module_reset_n, low_power_select, tx_lane,
               output sda_dev_o, sda_dev_oe_n, present_o, present_oe_n, int_o, int_oe_n, rx_lane);
  modport host (input sda, interrupt_n, module_present_n, rx_lane,
                output scl, sda_host_o, sda_host_oe_n, module_select_n, module_reset_n,
                low_power_select, tx_lane);
endinterface

// ===== rtl/msc_module.sv
// Operation
// [RQ1] Answer management only while select is low
// [RQ2] Host gives each module its own select
// [RQ3] Long reset low restores all defaults
// [RQ4] Host ignores status until completion interrupt
// [RQ5] Completion pulls interrupt low, clears pending flag
// [RQ6] Power-up posts completion without reset pulse
// [RQ7] Low power select limits module power
// [RQ8] Present line pulled to ground when inserted
// [RQ9] Interrupt low flags fault or critical status
// [RQ10] Host reads map to find interrupt source
// [RQ11] Interrupt only pulled low, host pulls up
// [RQ12] Map reached over two-wire link as target
// [RQ13] Two NRZ lanes combine into one PAM4
// [RQ14] PAM4 stream splits into two NRZ lanes
// [RQ15] Both electrical lanes pass through retimer
// [RQ16] Lanes three and four carry nothing
// [RQ17] Host supplies forward error correction; the host passes tx_data to the lanes with no coding
// [RQ18] Reset pulses below minimum length ignored
// [RQ19] Pending flag set from reset to completion
`timescale 1ns/1ps
`include "msc_map.svh"
module msc_module
  import msc_pkg::*;
#(
  parameter logic [15:0] RST_MIN_CYC = `MSC_RST_MIN_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic fault,
  output logic [1:0] opt_tx_sym,
  output logic opt_tx_en,
  input wire logic [1:0] opt_rx_sym,
  msc_if.dev lnk
);

  msc_link_t l_q;
  msc_link_t l_d;
  msc_core_t c_q;
  msc_core_t c_d;
  logic [7:0] rd_byte;
  logic wr_ev;

  ////////////////////////////////////////////////////////////////////////////
  // Map read decode from the synchronised map word
  function automatic logic [7:0] map_read(input logic [7:0] a, input logic [6:0] m);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      `MSC_ADDR_STATUS: r = {5'h00, m[`MSC_MAP_FAULT], m[`MSC_MAP_LOWPWR], m[`MSC_MAP_PENDING]};
      `MSC_ADDR_FLAGS: r = {6'h00, m[`MSC_MAP_FLAGS+1], m[`MSC_MAP_FLAGS]};
      `MSC_ADDR_CTRL: r = {6'h00, m[`MSC_MAP_CTRL+1], m[`MSC_MAP_CTRL]};
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: two-wire target clocked by the link clock
  assign rd_byte = map_read({l_q.addr[6:0], lnk.sda}, l_q.map_s2);

  always_comb begin
    l_d = l_q;
    l_d.map_s1 = c_q.map; // Quasi-static map word, each bit a level
    l_d.map_s2 = l_q.map_s1;
    if (lnk.module_select_n) begin
      // Deselected edge frames the link and drops all traffic
      l_d.cnt = 5'h00; // RQ1
      l_d.sda_oe_n = 1'b1; // RQ1
      // Write strobe drops here, which also gives it a known level after power-up
      l_d.wr_tog = 1'b0;
    end else begin
      if (l_q.cnt == 5'h00) begin
        l_d.rw = lnk.sda; // RQ12
      end else if (l_q.cnt <= `MSC_ADDR_LAST) begin
        l_d.addr = {l_q.addr[6:0], lnk.sda}; // RQ12
      end else if (!l_q.rw) begin
        l_d.sh = {l_q.sh[6:0], lnk.sda};
      end
      // Read data: drive low for zero bits, release for ones
      if (l_q.rw && l_q.cnt == `MSC_ADDR_LAST) begin
        l_d.sda_oe_n = rd_byte[7]; // RQ12
        l_d.sh = {rd_byte[6:0], 1'b0};
      end else if (l_q.rw && l_q.cnt > `MSC_ADDR_LAST && l_q.cnt < `MSC_DATA_LAST) begin
        l_d.sda_oe_n = l_q.sh[7];
        l_d.sh = {l_q.sh[6:0], 1'b0};
      end else begin
        l_d.sda_oe_n = 1'b1;
      end
      // Completed write raises a strobe that stands until the next framing edge
      if (!l_q.rw && l_q.cnt == `MSC_DATA_LAST) begin
        l_d.wr_addr = l_q.addr;
        l_d.wr_data = {l_q.sh[6:0], lnk.sda};
        l_d.wr_tog = 1'b1;
      end
      l_d.cnt = (l_q.cnt == `MSC_DATA_LAST) ? 5'h00 : l_q.cnt + 5'h01;
    end
  end

  // Link state register, framed by the deselected edge
  always_ff @(posedge lnk.scl) begin
    l_q <= l_d;
  end

  assign lnk.sda_dev_o = 1'b0;
  assign lnk.sda_dev_oe_n = l_q.sda_oe_n;

  ////////////////////////////////////////////////////////////////////////////
  // Core domain: reset filter, completion, flags, lanes
  assign wr_ev = c_q.tog_s2 & !c_q.tog_s3;

  always_comb begin
    c_d = c_q;
    c_d.rst_s1 = lnk.module_reset_n;
    c_d.rst_s2 = c_q.rst_s1;
    c_d.lp_s1 = lnk.low_power_select;
    c_d.lp_s2 = c_q.lp_s1;
    c_d.tog_s1 = l_q.wr_tog;
    c_d.tog_s2 = c_q.tog_s1;
    c_d.tog_s3 = c_q.tog_s2;
    c_d.fault_q = fault;
    // Count the length of a low reset level
    if (!c_q.rst_s2) begin
      c_d.low_cnt = (c_q.low_cnt == 16'hFFFF) ? c_q.low_cnt : c_q.low_cnt + 16'h0001;
    end else begin
      c_d.low_cnt = 16'h0000;
    end
    // Software writes; clear comes before set so a new event wins
    if (wr_ev && c_q.st == CORE_RUN) begin
      case (l_q.wr_addr)
        `MSC_ADDR_FLAGS: c_d.flags = c_q.flags & ~l_q.wr_data[1:0]; // RQ10
        `MSC_ADDR_CTRL: c_d.ctrl = l_q.wr_data[1:0];
        default: c_d.ctrl = c_q.ctrl;
      endcase
    end
    if (c_q.fault_q && c_q.st == CORE_RUN) begin
      c_d.flags[`MSC_FL_FAULT] = 1'b1; // RQ9
    end
    case (c_q.st)
      CORE_INIT: begin
        c_d.pending = 1'b1; // RQ19
        c_d.init_cnt = c_q.init_cnt + 16'h0001;
        if (c_q.init_cnt == `MSC_INIT_CYC - 16'h0001) begin
          c_d.st = CORE_RUN;
          c_d.pending = 1'b0; // RQ5
          c_d.flags[`MSC_FL_RSTDONE] = 1'b1; // RQ5
        end
      end
      CORE_HOLD: begin
        c_d.pending = 1'b1; // RQ19
        c_d.flags = 2'h0; // RQ3
        c_d.ctrl = `MSC_CTRL_RST; // RQ3
        c_d.init_cnt = 16'h0000;
        if (c_q.rst_s2) begin
          c_d.st = CORE_INIT;
        end
      end
      CORE_RUN: c_d.st = CORE_RUN;
      default: c_d.st = CORE_HOLD;
    endcase
    // Only a low level held for the full minimum starts a reset
    if (!c_q.rst_s2 && c_q.low_cnt >= RST_MIN_CYC - 16'h0001 && c_q.st != CORE_HOLD) begin // RQ18
      c_d.st = CORE_HOLD; // RQ3
      c_d.pending = 1'b1; // RQ19
      c_d.flags = 2'h0;
      c_d.ctrl = `MSC_CTRL_RST;
    end
    // Open-drain interrupt: enable pulls low, never driven high
    c_d.int_oe_n = !(c_d.flags[`MSC_FL_RSTDONE] ||
                     (c_d.flags[`MSC_FL_FAULT] && c_d.ctrl[`MSC_CT_FAULT_EN])); // RQ9 RQ11
    c_d.pres_oe_n = 1'b0; // RQ8
    // Retimed lanes, Gray PAM4 combine and split
    c_d.tx_ret = lnk.tx_lane[1:0]; // RQ15 RQ16
    c_d.tx_sym = msc_gray2(c_q.tx_ret); // RQ13
    c_d.tx_en = (c_q.st == CORE_RUN) && !c_q.lp_s2 && !c_q.ctrl[`MSC_CT_TX_OFF]; // RQ7
    c_d.rx_ret = opt_rx_sym; // RQ15
    c_d.rx_lane = {2'h0, msc_gray2(c_q.rx_ret)}; // RQ14 RQ16
    c_d.map = {c_q.ctrl, c_q.flags, c_q.fault_q, c_q.lp_s2, c_q.pending};
    // Power-up takes the completion path by itself
    if (!rstn) begin
      c_d = '0;
      c_d.st = CORE_INIT; // RQ6
      c_d.pending = 1'b1; // RQ19
      c_d.ctrl = `MSC_CTRL_RST;
      c_d.int_oe_n = 1'b1;
      c_d.rst_s1 = 1'b1;
      c_d.rst_s2 = 1'b1;
    end
  end

  // Core state register
  always_ff @(posedge clk) begin
    c_q <= c_d;
  end

  assign lnk.int_o = 1'b0;
  assign lnk.int_oe_n = c_q.int_oe_n;
  assign lnk.present_o = 1'b0;
  assign lnk.present_oe_n = c_q.pres_oe_n;
  assign lnk.rx_lane = c_q.rx_lane;
  assign opt_tx_sym = c_q.tx_sym;
  assign opt_tx_en = c_q.tx_en;
endmodule

// ===== rtl/msc_host.sv
`timescale 1ns/1ps
`include "msc_map.svh"
module msc_host
  import msc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic [7:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  input wire logic reset_req,
  input wire logic lp_req,
  output logic status_valid,
  output logic irq,
  output logic present,
  input wire logic [1:0] tx_data,
  output logic [1:0] rx_data,
  msc_if.host lnk
);

  localparam logic [7:0] HALF = 8'(`MSC_SCL_HALF_CYC - 1);

  msc_host_t q;
  msc_host_t d;

  ////////////////////////////////////////////////////////////////////////////
  // Link master: divided clock, select framing, bit transfer
  always_comb begin
    d = q;
    d.rsp_valid = 1'b0;
    d.int_s1 = lnk.interrupt_n;
    d.int_s2 = q.int_s1;
    d.pres_s1 = lnk.module_present_n;
    d.pres_s2 = q.pres_s1;
    // Data line comes from the target's clock domain
    d.sda_s1 = lnk.sda;
    d.sda_s2 = q.sda_s1;
    d.irq = !q.int_s2;
    d.present = !q.pres_s2; // RQ8
    d.lp = lp_req;
    d.tx_lane = {2'h0, tx_data}; // RQ16
    d.rx = lnk.rx_lane[1:0];
    // Status is trusted only after a completion interrupt
    if (q.irq && q.st != H_RST) begin
      d.stat_valid = 1'b1; // RQ4
    end
    case (q.st)
      H_IDLE: begin
        if (reset_req) begin
          d.st = H_RST;
          d.ready = 1'b0;
          d.rst_n = 1'b0;
          d.rst_cnt = 16'h0000;
          d.stat_valid = 1'b0; // RQ4
        end else if (cmd_valid) begin
          d.st = H_LOW;
          d.ready = 1'b0;
          d.busy = 1'b1;
          d.rd_op = cmd_read;
          d.frm = {cmd_read, cmd_addr, cmd_wdata}; // RQ12
          d.hb = 5'h00;
          d.div = 8'h00;
          d.scl = 1'b0;
        end
      end
      H_LOW: begin
        d.div = q.div + 8'h01;
        if (q.div == HALF) begin
          if (q.rd_op && q.hb >= `MSC_HB_FIRST_DATA) begin
            d.rd = {q.rd[6:0], q.sda_s2}; // RQ10
          end
          d.div = 8'h00;
          d.scl = 1'b1;
          d.st = H_HIGH;
        end
      end
      H_HIGH: begin
        d.div = q.div + 8'h01;
        if (q.div == HALF) begin
          d.div = 8'h00;
          d.hb = q.hb + 5'h01;
          if (q.hb == `MSC_HB_LAST || !q.busy) begin
            d.st = H_IDLE;
            d.sel_n = 1'b1;
            d.sda_oe_n = 1'b1;
            d.ready = 1'b1;
            d.rsp_valid = q.busy;
            d.rsp_data = q.rd;
            d.busy = 1'b0;
          end else begin
            // Select and data change only while the clock is low
            d.scl = 1'b0;
            d.sel_n = 1'b0; // RQ2
            d.st = H_LOW;
            if (q.rd_op && q.hb + 5'h01 >= `MSC_HB_FIRST_DATA) begin
              d.sda_oe_n = 1'b1;
            end else begin
              d.sda_oe_n = q.frm[16];
              d.frm = {q.frm[15:0], 1'b1};
            end
          end
        end
      end
      H_RST: begin
        d.rst_cnt = q.rst_cnt + 16'h0001;
        if (q.rst_cnt == `MSC_HOST_RST_CYC - 16'h0001) begin
          d.rst_n = 1'b1;
          d.ready = 1'b1;
          d.st = H_IDLE;
        end
      end
      default: d.st = H_IDLE;
    endcase
    // After reset one deselected clock frames the target
    if (!rstn) begin
      d = '0;
      d.st = H_LOW;
      d.sel_n = 1'b1;
      d.sda_oe_n = 1'b1;
      d.rst_n = 1'b1;
      d.int_s1 = 1'b1;
      d.int_s2 = 1'b1;
      d.pres_s1 = 1'b1;
      d.pres_s2 = 1'b1;
    end
  end

  // Host state register
  always_ff @(posedge clk) begin
    q <= d;
  end

  assign lnk.scl = q.scl;
  assign lnk.sda_host_o = 1'b0;
  assign lnk.sda_host_oe_n = q.sda_oe_n;
  assign lnk.module_select_n = q.sel_n;
  assign lnk.module_reset_n = q.rst_n;
  assign lnk.low_power_select = q.lp;
  assign lnk.tx_lane = q.tx_lane;
  assign cmd_ready = q.ready;
  assign rsp_valid = q.rsp_valid;
  assign rsp_rdata = q.rsp_data;
  assign status_valid = q.stat_valid;
  assign irq = q.irq;
  assign present = q.present;
  assign rx_data = q.rx;
endmodule

// ===== bench/msc_assertions.sv
`timescale 1ns/1ps
module msc_assertions #(
  parameter logic [15:0] RST_MIN_CYC = 16'h0014
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic scl,
  input wire logic sda_dev_oe_n,
  input wire logic module_select_n,
  input wire logic module_reset_n,
  input wire logic module_present_n,
  input wire logic int_o,
  input wire logic int_oe_n,
  input wire logic interrupt_n,
  input wire logic [3:0] tx_lane,
  input wire logic [3:0] rx_lane
);
  logic [15:0] low_q;
  logic [7:0] up_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Length of the current reset low and cycles since system reset
  always_ff @(posedge clk) begin
    if (!rstn) begin
      low_q <= 16'h0000;
      up_q <= 8'h00;
    end else begin
      low_q <= module_reset_n ? 16'h0000 : low_q + 16'h0001;
      up_q <= up_q + {7'h00, up_q != 8'hFF};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Properties on the wires between the two ends
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_int_low_only: assert property (
    !int_oe_n |-> !int_o) else $error("interrupt line driven high");
  a_present_grounded: assert property (
    !module_present_n) else $error("present line not low");
  a_rx_unused_quiet: assert property (
    rx_lane[3:2] == 2'h0) else $error("unused receive lanes active");
  a_tx_unused_quiet: assert property (
    tx_lane[3:2] == 2'h0) else $error("unused transmit lanes active");
  a_unselected_released: assert property (
    $rose(scl) && module_select_n |-> ##[1:4] sda_dev_oe_n) else $error("data driven while unselected");
  a_long_reset_release: assert property (
    low_q == RST_MIN_CYC + 16'h0008 |-> int_oe_n) else $error("interrupt held through long reset");
  a_completion_post: assert property (
    $rose(module_reset_n) && low_q > RST_MIN_CYC + 16'h0008 |-> interrupt_n [*8] ##[8:20] !interrupt_n)
    else $error("no completion interrupt after reset");
  a_powerup_post: assert property (
    up_q == 8'h28 |-> !interrupt_n) else $error("no completion interrupt at power-up");
endmodule

// ===== bench/module_sideband_control_test.sv
`timescale 1ns/1ps
module module_sideband_control_test;
  typedef struct packed {logic rd; logic [7:0] addr; logic [7:0] wdata; logic [7:0] exp;} msc_row_t;
  localparam logic [15:0] RMIN = 16'h0004;
  logic clk, rstn, fault, opt_tx_en, cmd_valid, cmd_ready, cmd_read, rsp_valid;
  logic reset_req, lp_req, status_valid, irq, present;
  logic [1:0] opt_tx_sym, opt_rx_sym, tx_data, rx_data;
  logic [7:0] cmd_addr, cmd_wdata, rsp_rdata;
  int err_count, n_checks;
  // Ordinary map traffic: read flag, address, write data, expected read data
  msc_row_t rows [0:6] = '{
    '{1'b1, 8'h00, 8'h00, 8'h00},
    '{1'b1, 8'h01, 8'h00, 8'h01},
    '{1'b0, 8'h01, 8'h01, 8'h00},
    '{1'b1, 8'h01, 8'h00, 8'h00},
    '{1'b0, 8'h02, 8'h03, 8'h00},
    '{1'b1, 8'h02, 8'h00, 8'h03},
    '{1'b1, 8'h05, 8'h00, 8'h00}
  };

  ////////////////////////////////////////////////////////////////////////////////
  // Both ends joined through the link
  msc_if lnk_if();
  msc_module #(.RST_MIN_CYC(RMIN)) i_msc_module (.clk(clk), .rstn(rstn), .fault(fault),
    .opt_tx_sym(opt_tx_sym), .opt_tx_en(opt_tx_en), .opt_rx_sym(opt_rx_sym), .lnk(lnk_if.dev));
  msc_host i_msc_host (.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_read(cmd_read), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .reset_req(reset_req), .lp_req(lp_req), .status_valid(status_valid),
    .irq(irq), .present(present), .tx_data(tx_data), .rx_data(rx_data), .lnk(lnk_if.host));
  msc_assertions #(.RST_MIN_CYC(RMIN)) i_msc_assertions (.clk(clk), .rstn(rstn), .scl(lnk_if.scl),
    .sda_dev_oe_n(lnk_if.sda_dev_oe_n), .module_select_n(lnk_if.module_select_n),
    .module_reset_n(lnk_if.module_reset_n), .module_present_n(lnk_if.module_present_n),
    .int_o(lnk_if.int_o), .int_oe_n(lnk_if.int_oe_n), .interrupt_n(lnk_if.interrupt_n),
    .tx_lane(lnk_if.tx_lane), .rx_lane(lnk_if.rx_lane));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, 5 ns period
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wait_hi(ref logic s, input int lim);
    int i;
    i = 0;
    while (s !== 1'b1 && i < lim) begin
      tick(1);
      i++;
    end
    if (s !== 1'b1) begin
      err_count++;
      $display("unexpected timeout expected 1 seen %b", s);
      conclude();
    end
  endtask

  // One management frame, request held for one clock once ready is high, then wait for the response
  task automatic cmd(input msc_row_t r);
    wait_hi(cmd_ready, 12000);
    cmd_valid = 1'b1;
    cmd_read = r.rd;
    cmd_addr = r.addr;
    cmd_wdata = r.wdata;
    tick(1);
    cmd_valid = 1'b0;
    wait_hi(rsp_valid, 12000);
    if (r.rd) check("read data", r.exp, rsp_rdata);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rstn = 1'b0;
    fault = 1'b0;
    opt_rx_sym = 2'h0;
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_addr = 8'h00;
    cmd_wdata = 8'h00;
    reset_req = 1'b0;
    lp_req = 1'b0;
    tx_data = 2'h0;
    err_count = 0;
    n_checks = 0;
    tick(8);
    rstn = 1'b1;
    tick(40);
    check("present", 8'h01, {7'h00, present});
    check("irq at power-up", 8'h01, {7'h00, irq});
    // Lane gearing in both directions over all four levels
    for (int v = 0; v < 4; v++) begin
      tx_data = v[1:0];
      opt_rx_sym = v[1:0];
      tick(6);
      check("tx symbol", {6'h00, v[1], v[1] ^ v[0]}, {6'h00, opt_tx_sym});
      check("rx data", {6'h00, v[1], v[1] ^ v[0]}, {6'h00, rx_data});
    end
    foreach (rows[i]) cmd(rows[i]);
    check("irq after clear", 8'h00, {7'h00, irq});
    check("tx enable off", 8'h00, {7'h00, opt_tx_en});
    // Fault with its interrupt enabled
    fault = 1'b1;
    tick(8);
    fault = 1'b0;
    tick(4);
    check("irq on fault", 8'h01, {7'h00, irq});
    // Full reset through the link
    reset_req = 1'b1;
    tick(1);
    reset_req = 1'b0;
    tick(30);
    check("status during reset", 8'h00, {7'h00, status_valid});
    check("irq during reset", 8'h00, {7'h00, irq});
    wait_hi(status_valid, 400);
    check("irq after reset", 8'h01, {7'h00, irq});
    tick(2);
    check("tx enable default", 8'h01, {7'h00, opt_tx_en});
    lp_req = 1'b1;
    tick(6);
    check("tx enable low power", 8'h00, {7'h00, opt_tx_en});
    lp_req = 1'b0;
    cmd('{1'b1, 8'h02, 8'h00, 8'h01});
    conclude();
  end
endmodule
